// file: verilog/drive_ctrl_decoder.sv
// drive control word decoder: control word and speed setpoint to drive commands
// assumes process data words come from fieldbus logic on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "drive_ctrl_consts.svh"
module drive_ctrl_decoder
  import drive_ctrl_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CLK_EN_I,
  // process data from fieldbus
  input wire logic [15:0] DRIVE_CONTROL_WORD_I,
  input wire logic [15:0] SPEED_SETPOINT_WORD_I,
  // configuration
  input wire logic [9:0] TELEGRAM_SELECT_I,
  input wire logic [15:0] REFERENCE_SPEED_I,
  input wire logic QUICK_STOP_SOURCE_A_I,
  input wire logic QUICK_STOP_SOURCE_B_I,
  input wire logic ACK_SOURCE_1_I,
  input wire logic ACK_SOURCE_2_I,
  input wire logic ACK_SOURCE_3_I,
  input wire logic LOCAL_CONTROL_WORD_EN_I,
  input wire logic [15:0] LOCAL_CONTROL_WORD_I,
  // drive feedback
  input wire logic ZERO_SPEED_I,
  // drive commands
  output logic PULSE_ENABLE_O,
  output logic LINE_CONTACTOR_O,
  output logic READY_FOR_OPERATION_O,
  output logic COAST_STOP_ACTIVE_O,
  output logic QUICK_STOP_ACTIVE_O,
  output logic FAULT_ACK_O,
  output logic MASTER_CONTROL_O,
  output logic COMMAND_SET_SELECT_O,
  output logic signed [15:0] MOP_SETPOINT_O,
  output logic signed [15:0] RAMP_OUTPUT_O,
  output logic signed [31:0] SPEED_SETPOINT_O
);
  ramp_if rif();
  seq_state_e state;
  seq_state_e next_state;
  logic [15:0] word;
  logic [15:0] prev_word;
  logic ack_src_1_s1, ack_src_1_s2, ack_src_1_q;
  logic ack_src_2_s1, ack_src_2_s2, ack_src_2_q;
  logic ack_src_3_s1, ack_src_3_s2, ack_src_3_q;
  logic qs_a_s1, qs_a_s2, qs_b_s1, qs_b_s2;
  logic on_cmd, coast_ok, qstop_ok, enop, ack_edge, tel_mop, tel_cmd_set;
  logic mop_up, mop_dn;
  logic [7:0] mop_cnt;
  speed_t sp_word;

  function automatic logic tel_is(input logic [9:0] t, input logic [9:0] v);
    tel_is = (t == v);
  endfunction

  function automatic logic signed [31:0] scale_speed(input speed_t sp, input logic [15:0] ref_s);
    logic signed [32:0] prod;
    prod = 33'(sp) * $signed({1'b0, ref_s});
    scale_speed = 32'(prod >>> `SP_FRAC_BITS);
  endfunction

  // external binary sources are asynchronous to this clock
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ack_src_1_s1 <= 1'b0;
      ack_src_1_s2 <= 1'b0;
      ack_src_1_q <= 1'b0;
      ack_src_2_s1 <= 1'b0;
      ack_src_2_s2 <= 1'b0;
      ack_src_2_q <= 1'b0;
      ack_src_3_s1 <= 1'b0;
      ack_src_3_s2 <= 1'b0;
      ack_src_3_q <= 1'b0;
      qs_a_s1 <= 1'b1;
      qs_a_s2 <= 1'b1;
      qs_b_s1 <= 1'b1;
      qs_b_s2 <= 1'b1;
    end else if (CLK_EN_I) begin
      ack_src_1_s1 <= ACK_SOURCE_1_I;
      ack_src_1_s2 <= ack_src_1_s1;
      ack_src_1_q <= ack_src_1_s2;
      ack_src_2_s1 <= ACK_SOURCE_2_I;
      ack_src_2_s2 <= ack_src_2_s1;
      ack_src_2_q <= ack_src_2_s2;
      ack_src_3_s1 <= ACK_SOURCE_3_I;
      ack_src_3_s2 <= ack_src_3_s1;
      ack_src_3_q <= ack_src_3_s2;
      qs_a_s1 <= QUICK_STOP_SOURCE_A_I;
      qs_a_s2 <= qs_a_s1;
      qs_b_s1 <= QUICK_STOP_SOURCE_B_I;
      qs_b_s2 <= qs_b_s1;
    end
  end

  // word selection: fieldbus word only while master control bit is set
  always_comb begin
    if (DRIVE_CONTROL_WORD_I[`BIT_MASTER] && !LOCAL_CONTROL_WORD_EN_I) begin
      word = DRIVE_CONTROL_WORD_I;
      sp_word = speed_t'(SPEED_SETPOINT_WORD_I);
    end else begin
      word = LOCAL_CONTROL_WORD_I;
      sp_word = '0;
    end
  end

  always_comb begin
    on_cmd = word[`BIT_ON];
    coast_ok = word[`BIT_COAST];
    qstop_ok = word[`BIT_QSTOP] & qs_a_s2 & qs_b_s2;
    enop = word[`BIT_ENOP];
    tel_mop = tel_is(TELEGRAM_SELECT_I, `TEL_STD1) || tel_is(TELEGRAM_SELECT_I, `TEL_STD352);
    tel_cmd_set = tel_is(TELEGRAM_SELECT_I, `TEL_STD20);
    // bits 8, 9, 11, 12 are never read
    mop_up = tel_mop && word[`BIT_MOP_UP] && !word[`BIT_MOP_DN];
    mop_dn = tel_mop && word[`BIT_MOP_DN] && !word[`BIT_MOP_UP];
    ack_edge = (word[`BIT_ACK] && !prev_word[`BIT_ACK])
      || (ack_src_1_s2 && !ack_src_1_q) || (ack_src_2_s2 && !ack_src_2_q)
      || (ack_src_3_s2 && !ack_src_3_q);
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      prev_word <= '0;
    end else if (CLK_EN_I) begin
      prev_word <= word;
    end
  end

  // sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_INHIBIT: begin
        if (on_cmd && !prev_word[`BIT_ON] && coast_ok && qstop_ok) begin
          next_state = ST_READY;
        end
      end
      ST_READY: begin
        if (!coast_ok) next_state = ST_INHIBIT;
        else if (!qstop_ok) next_state = ST_QUICK_STOP;
        else if (!on_cmd) next_state = ST_INHIBIT;
        else if (enop) next_state = ST_RUN;
      end
      ST_RUN: begin
        if (!coast_ok) next_state = ST_INHIBIT;
        else if (!qstop_ok) next_state = ST_QUICK_STOP;
        else if (!on_cmd) next_state = ST_RAMP_STOP;
        else if (!enop) next_state = ST_READY;
      end
      ST_RAMP_STOP: begin
        if (!coast_ok) next_state = ST_INHIBIT;
        else if (!qstop_ok) next_state = ST_QUICK_STOP;
        else if (ZERO_SPEED_I && rif.out == 0) next_state = ST_INHIBIT;
      end
      ST_QUICK_STOP: begin
        if (!coast_ok || (ZERO_SPEED_I && rif.out == 0)) next_state = ST_INHIBIT;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state <= ST_INHIBIT;
    end else if (CLK_EN_I) begin
      state <= next_state;
    end
  end

  // ramp generator control
  always_comb begin
    rif.quick = (state == ST_QUICK_STOP);
    rif.rfg_zero = (state == ST_RUN) && !word[`BIT_RFG_EN];
    rif.rfg_hold = (state == ST_RUN) && !word[`BIT_RFG_RUN];
    if (state == ST_RUN && word[`BIT_SP_EN]) begin
      rif.target = sp_word;
    end else begin
      rif.target = '0;
    end
    if (state == ST_INHIBIT || state == ST_READY) begin
      rif.rfg_zero = 1'b1;
    end
  end

  ramp_gen u_ramp (
    .clk(CORE_CLK_I),
    .rst_n(RESET_N_I),
    .ce(CLK_EN_I),
    .rif(rif)
  );

  // motorized potentiometer, one step per tick
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mop_cnt <= '0;
      MOP_SETPOINT_O <= '0;
    end else if (CLK_EN_I) begin
      if (mop_cnt == 8'(`MOP_DIV - 1)) begin
        mop_cnt <= '0;
        // saturate so the setpoint never wraps sign
        if (mop_up && MOP_SETPOINT_O != 16'sh7FFF) begin
          MOP_SETPOINT_O <= MOP_SETPOINT_O + 16'sh0001;
        end else if (mop_dn && MOP_SETPOINT_O != -16'sh7FFF) begin
          MOP_SETPOINT_O <= MOP_SETPOINT_O - 16'sh0001;
        end
      end else begin
        mop_cnt <= mop_cnt + 8'h01;
      end
    end
  end

  // registered command outputs
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PULSE_ENABLE_O <= 1'b0;
      LINE_CONTACTOR_O <= 1'b0;
      READY_FOR_OPERATION_O <= 1'b0;
      COAST_STOP_ACTIVE_O <= 1'b0;
      QUICK_STOP_ACTIVE_O <= 1'b0;
      FAULT_ACK_O <= 1'b0;
      MASTER_CONTROL_O <= 1'b0;
      COMMAND_SET_SELECT_O <= 1'b0;
      RAMP_OUTPUT_O <= '0;
      SPEED_SETPOINT_O <= '0;
    end else if (CLK_EN_I) begin
      PULSE_ENABLE_O <= (next_state == ST_RUN) || (next_state == ST_RAMP_STOP)
        || (next_state == ST_QUICK_STOP);
      LINE_CONTACTOR_O <= (next_state != ST_INHIBIT);
      READY_FOR_OPERATION_O <= (next_state == ST_READY) || (next_state == ST_RUN);
      COAST_STOP_ACTIVE_O <= !coast_ok;
      QUICK_STOP_ACTIVE_O <= !qstop_ok;
      FAULT_ACK_O <= ack_edge;
      MASTER_CONTROL_O <= DRIVE_CONTROL_WORD_I[`BIT_MASTER];
      COMMAND_SET_SELECT_O <= tel_cmd_set && word[`BIT_CMD_SET0];
      RAMP_OUTPUT_O <= rif.out;
      SPEED_SETPOINT_O <= scale_speed(rif.out, REFERENCE_SPEED_I);
    end
  end

  coast_stop_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    CLK_EN_I && !coast_ok |=> !PULSE_ENABLE_O && !LINE_CONTACTOR_O)
    else $error("coast stop kept pulses");
  quick_and_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    CLK_EN_I && word[`BIT_QSTOP] && !(qs_a_s2 && qs_b_s2) |=> QUICK_STOP_ACTIVE_O)
    else $error("quick stop source ignored");
  inhibit_ready_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    CLK_EN_I && state == ST_RUN && coast_ok && qstop_ok && on_cmd && !enop
    |=> !PULSE_ENABLE_O && READY_FOR_OPERATION_O) else $error("inhibit wrong");
  switch_on_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    CLK_EN_I && state == ST_INHIBIT && on_cmd && prev_word[`BIT_ON]
    |=> state == ST_INHIBIT) else $error("switch on without edge");
  // a held ack bit with no source edge must not repeat the pulse
  ack_static_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    CLK_EN_I && word[`BIT_ACK] && prev_word[`BIT_ACK] && !(ack_src_1_s2 && !ack_src_1_q)
    && !(ack_src_2_s2 && !ack_src_2_q) && !(ack_src_3_s2 && !ack_src_3_q)
    |=> !FAULT_ACK_O) else $error("ack held");
  ack_word_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    CLK_EN_I && word[`BIT_ACK] && !prev_word[`BIT_ACK] |=> FAULT_ACK_O)
    else $error("ack edge lost");
  ack_src_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    CLK_EN_I && ack_src_2_s2 && !ack_src_2_q |=> FAULT_ACK_O)
    else $error("source ack lost");
  cmd_set_tel_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    CLK_EN_I && !tel_cmd_set |=> !COMMAND_SET_SELECT_O)
    else $error("command set outside tel 20");
  mop_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    CLK_EN_I && (word[`BIT_MOP_UP] == word[`BIT_MOP_DN] || !tel_mop)
    |=> $stable(MOP_SETPOINT_O)) else $error("mop moved");
  setpoint_gate_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    !word[`BIT_SP_EN] |-> rif.target == 0) else $error("setpoint not gated");
endmodule
`default_nettype wire

// file: shared/drive_ctrl_consts.svh
// constants for the drive control word decoder
// assumes inclusion by bare name from package and modules
`ifndef DRIVE_CTRL_CONSTS_SVH
`define DRIVE_CTRL_CONSTS_SVH
`define BIT_ON 0
`define BIT_COAST 1
`define BIT_QSTOP 2
`define BIT_ENOP 3
`define BIT_RFG_EN 4
`define BIT_RFG_RUN 5
`define BIT_SP_EN 6
`define BIT_ACK 7
`define BIT_MASTER 10
`define BIT_MOP_UP 13
`define BIT_MOP_DN 14
`define BIT_CMD_SET0 15
`define TEL_STD1 10'h001
`define TEL_STD20 10'h014
`define TEL_STD352 10'h160
`define TEL_FREE 10'h3E7
`define SP_UNITY 16'h4000
`define SP_FRAC_BITS 14
`define RAMP_STEP 16'h0010
`define QRAMP_STEP 16'h0040
`define MOP_STEP 16'h0001
`define MOP_TIME_NS 1000
`define CLK_PERIOD_NS 40
`define MOP_DIV ((`MOP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: shared/drive_ctrl_pkg.sv
// types for the drive control word decoder
// assumes the consts header is on the include path
package drive_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_INHIBIT, ST_READY, ST_RUN, ST_RAMP_STOP, ST_QUICK_STOP
  } seq_state_e;
  typedef logic signed [15:0] speed_t;
endpackage

// file: shared/ramp_if.sv
// ramp generator control bundle between top and ramp module
// assumes one clock domain
`timescale 1ns/1ns
`default_nettype none
interface ramp_if;
  import drive_ctrl_pkg::*;
  speed_t target;
  logic rfg_zero;
  logic rfg_hold;
  logic quick;
  speed_t out;
  modport ctrl(output target, output rfg_zero, output rfg_hold, output quick, input out);
  modport gen(input target, input rfg_zero, input rfg_hold, input quick, output out);
endinterface
`default_nettype wire

// file: verilog/ramp_gen.sv
// ramp-function generator with zero and hold controls
// assumes target from ctrl side on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "drive_ctrl_consts.svh"
module ramp_gen
  import drive_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  ramp_if.gen rif
);
  speed_t step;
  speed_t diff;
  always_comb begin
    step = rif.quick ? speed_t'(`QRAMP_STEP) : speed_t'(`RAMP_STEP);
    diff = speed_t'(rif.target - rif.out);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rif.out <= '0;
    end else if (ce) begin
      if (rif.rfg_zero) begin
        rif.out <= '0;
      end else if (!rif.rfg_hold) begin
        if (diff > step) begin
          rif.out <= speed_t'(rif.out + step);
        end else if (diff < -step) begin
          rif.out <= speed_t'(rif.out - step);
        end else begin
          rif.out <= rif.target;
        end
      end
    end
  end
  rfg_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && rif.rfg_zero |=> rif.out == 0) else $error("ramp not zeroed");
  rfg_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && rif.rfg_hold && !rif.rfg_zero |=> $stable(rif.out))
    else $error("ramp moved on hold");
endmodule
`default_nettype wire

// file: bench/fieldbus_master.sv
// fieldbus master model: holds the cyclic process data words
// assumes send is called just after a falling clock edge
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master (
  // process data to the drive
  output logic [15:0] control_word_o,
  output logic [15:0] setpoint_word_o
);
  logic [15:0] pdw [2];
  // first word is always the control word
  assign control_word_o = pdw[0];
  assign setpoint_word_o = pdw[1];
  // master control stays low until the drive is out of reset
  initial begin
    pdw[0] = 16'h0000;
    pdw[1] = 16'h0000;
  end
  task automatic send(input logic [15:0] cw, input logic [15:0] sp);
    pdw[0] = cw;
    pdw[1] = sp;
  endtask
endmodule
`default_nettype wire

// file: bench/drive_ctrl_decoder_test.sv
// self-checking bench for the drive control word decoder
// assumes the fieldbus_master model and one 25 MHz clock
`timescale 1ns/1ns
`default_nettype none
module drive_ctrl_decoder_test;
  import drive_ctrl_pkg::*;
  typedef struct {logic [31:0] exp; int sel; bit word;} note_s;
  note_s notes[$];
  event sample_ev;
  int miscompares = 0;
  int tests_run = 0;
  int acks = 0;
  int seed = 32'haf3c;
  int base;
  logic clk = 0;
  logic rst_n = 0;
  logic ce = 1;
  logic local_en = 0;
  logic zs = 1;
  logic qs_a = 1;
  logic qs_b = 1;
  logic [2:0] ack = 3'h0;
  logic [9:0] tel = 10'h001;
  logic [15:0] ref_spd = 16'h4000;
  logic [15:0] local_w = 16'h0000;
  logic [15:0] sp = 16'h0000;
  logic [15:0] cw_w, sp_w;
  logic pe, lc, rdy, coast, qs, fack, mst, css;
  logic signed [15:0] mop, ramp, snap;
  logic signed [31:0] spd;
  fieldbus_master u_master (.control_word_o(cw_w), .setpoint_word_o(sp_w));
  drive_ctrl_decoder dut (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(ce),
    .DRIVE_CONTROL_WORD_I(cw_w), .SPEED_SETPOINT_WORD_I(sp_w),
    .TELEGRAM_SELECT_I(tel), .REFERENCE_SPEED_I(ref_spd),
    .QUICK_STOP_SOURCE_A_I(qs_a), .QUICK_STOP_SOURCE_B_I(qs_b),
    .ACK_SOURCE_1_I(ack[0]), .ACK_SOURCE_2_I(ack[1]), .ACK_SOURCE_3_I(ack[2]),
    .LOCAL_CONTROL_WORD_EN_I(local_en), .LOCAL_CONTROL_WORD_I(local_w),
    .ZERO_SPEED_I(zs), .PULSE_ENABLE_O(pe), .LINE_CONTACTOR_O(lc),
    .READY_FOR_OPERATION_O(rdy), .COAST_STOP_ACTIVE_O(coast),
    .QUICK_STOP_ACTIVE_O(qs), .FAULT_ACK_O(fack), .MASTER_CONTROL_O(mst),
    .COMMAND_SET_SELECT_O(css), .MOP_SETPOINT_O(mop), .RAMP_OUTPUT_O(ramp),
    .SPEED_SETPOINT_O(spd));
  initial forever #20 clk = ~clk;
  // ack is a one-cycle pulse, so count it every edge
  always @(posedge clk) if (fack === 1'b1) acks <= acks + 1;
  function automatic logic [31:0] obs(input int sel);
    case (sel)
      0: return 32'(pe);
      1: return 32'(lc);
      2: return 32'(rdy);
      3: return 32'(coast);
      4: return 32'(qs);
      5: return 32'(mst);
      6: return 32'(css);
      7: return 32'(ramp);
      8: return spd;
      9: return 32'(acks);
      10: return 32'(mop == snap);
      11: return 32'(mop < snap);
      default: return 32'(mop > snap);
    endcase
  endfunction
  task automatic cmp_bit(input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t flag got %b want %b", $time, g, e);
    end
  endtask
  task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t word got %h want %h", $time, g, e);
    end
  endtask
  // checker side: drains every queued note, oldest first, whenever a result is sampled
  initial begin
    note_s n;
    logic [31:0] got;
    forever begin
      @(sample_ev);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        got = obs(n.sel);
        if (n.word) cmp_word(n.exp, got);
        else cmp_bit(n.exp[0], got[0]);
      end
    end
  end
  task automatic put(input int sel, input logic [31:0] e, input bit w);
    notes.push_back('{e, sel, w});
    ->sample_ev;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  // reserved positions get random noise on every word
  task automatic send(input logic [15:0] cw);
    u_master.send(cw | (16'($random(seed)) & 16'h1B00), sp);
  endtask
  task automatic switch_on();
    send(16'h0406);
    step(4);
    send(16'h0407);
    step(4);
    send(16'h047F);
    step(4);
  endtask
  // mop moves one step per 25 clocks, so 60 clocks spans at least two steps
  task automatic mop_try(input logic [15:0] cw, input int sel);
    send(cw);
    step(2);
    snap = mop;
    step(60);
    put(sel, 1, 0);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(6000 * 40);
    miscompares++;
    summarize();
  end
  initial begin
    step(8);
    rst_n = 1;
    put(0, 0, 0);
    put(1, 0, 0);
    step(2);
    sp = 16'h0100;
    switch_on();
    step(30);
    put(1, 1, 0);
    put(2, 1, 0);
    put(0, 1, 0);
    put(5, 1, 0);
    put(7, 32'h0000_0100, 1);
    put(8, 32'h0000_0100, 1);
    sp = 16'h0200;
    send(16'h045F);
    step(10);
    put(7, 32'h0000_0100, 1);
    send(16'h047F);
    step(30);
    put(7, 32'h0000_0200, 1);
    send(16'h046F);
    step(4);
    put(7, 32'h0000_0000, 1);
    send(16'h047F);
    step(40);
    send(16'h043F);
    step(40);
    put(7, 32'h0000_0000, 1);
    sp = 16'hFF00;
    send(16'h047F);
    step(30);
    put(7, 32'hFFFF_FF00, 1);
    put(8, 32'hFFFF_FF00, 1);
    ref_spd = 16'h8000;
    step(4);
    put(8, 32'hFFFF_FE00, 1);
    done("ramp");
    send(16'h0477);
    step(4);
    put(0, 0, 0);
    put(2, 1, 0);
    send(16'h047F);
    step(4);
    put(0, 1, 0);
    base = acks;
    send(16'h04FF);
    step(8);
    put(9, 32'(base + 1), 1);
    send(16'h047F);
    for (int i = 0; i < 3; i++) begin
      base = acks;
      ack[i] = 1'b1;
      step(3);
      ack[i] = 1'b0;
      step(6);
      put(9, 32'(base + 1), 1);
    end
    done("ack");
    mop_try(16'h247F, 12);
    mop_try(16'h647F, 10);
    mop_try(16'h047F, 10);
    mop_try(16'h447F, 11);
    tel = 10'h014;
    mop_try(16'h247F, 10);
    send(16'h847F);
    step(4);
    put(6, 1, 0);
    tel = 10'h001;
    step(4);
    put(6, 0, 0);
    tel = 10'h160;
    mop_try(16'h247F, 12);
    tel = 10'h3E7;
    mop_try(16'h447F, 10);
    done("potentiometer");
    // clock enable low: a coast stop must wait until it returns
    ce = 0;
    send(16'h047D);
    step(6);
    put(0, 1, 0);
    put(3, 0, 0);
    ce = 1;
    step(2);
    put(3, 1, 0);
    put(0, 0, 0);
    switch_on();
    send(16'h047F);
    step(30);
    zs = 0;
    send(16'h047E);
    step(4);
    put(0, 1, 0);
    zs = 1;
    step(40);
    put(0, 0, 0);
    put(1, 0, 0);
    for (int i = 0; i < 3; i++) begin
      switch_on();
      qs_a = (i != 0);
      qs_b = (i != 1);
      if (i == 2) send(16'h047B);
      step(8);
      put(4, 1, 0);
      qs_a = 1;
      qs_b = 1;
      send(16'h047E);
      step(40);
    end
    switch_on();
    send(16'h047D);
    step(2);
    put(0, 0, 0);
    put(1, 0, 0);
    put(3, 1, 0);
    step(8);
    switch_on();
    send(16'h007F);
    step(40);
    put(5, 0, 0);
    put(1, 0, 0);
    // local word overrides the fieldbus word while forced
    local_en = 1;
    local_w = 16'h0006;
    send(16'h047F);
    step(4);
    put(5, 1, 0);
    put(1, 0, 0);
    local_w = 16'h0007;
    step(4);
    put(1, 1, 0);
    local_en = 0;
    done("stops");
    step(4);
    summarize();
  end
endmodule
`default_nettype wire
